// file: pesd_params.svh
`ifndef PESD_PARAMS_SVH
`define PESD_PARAMS_SVH
// ============================================================
// event select and increment field widths
`define PESD_CODE_W      6
`define PESD_AMT_W       2
// ============================================================
// event numbers, shared by both counters
`define PESD_EV_LOCKED   6'h1c
`define PESD_EV_IOCYC    6'h1d
`define PESD_EV_NCREQ    6'h1e
`define PESD_EV_AGI      6'h1f
`define PESD_EV_FPOP     6'h22
`define PESD_EV_BP0      6'h23
`define PESD_EV_BP1      6'h24
`define PESD_EV_BP2      6'h25
`define PESD_EV_BP3      6'h26
`define PESD_EV_HWINT    6'h27
`define PESD_EV_RDWR     6'h28
`define PESD_EV_RWMISS   6'h29
`define PESD_EV_MMPIPE   6'h2b
`define PESD_EV_MMCLR    6'h2d
`define PESD_EV_SAT      6'h2f
`define PESD_EV_MMRD     6'h31
`define PESD_EV_TAKEN    6'h32
`define PESD_EV_RETPRED  6'h37
`define PESD_EV_MMSTALL  6'h38
`define PESD_EV_RETURN   6'h39
`define PESD_EV_BTBERR   6'h3a
`define PESD_EV_WRSTALL  6'h3b
`define PESD_EV_RSVD_LO  6'h3c
`define PESD_EV_RSVD_HI  6'h3f
`define PESD_EV_L2TLB    6'h40
`define PESD_EV_L1TLBD   6'h41
`define PESD_EV_L1TLBC   6'h42
`define PESD_EV_L1TLB    6'h43
`define PESD_EV_FLUSH    6'h44
`define PESD_EV_INVAL    6'h45
`define PESD_EV_INVHIT   6'h46
`define PESD_EV_RSVD_47  6'h47
`define PESD_EV_DECODE   6'h48
`define PESD_EV_RSVD_49  6'h49
// ============================================================
// increment amounts
`define PESD_AMT_NONE    2'h0
`define PESD_AMT_ONE     2'h1
`define PESD_AMT_TWO     2'h2
`endif

// file: pesd_pkg.sv
// ============================================================
// shared types
package pesd_pkg;
  `include "pesd_params.svh"
  typedef logic [`PESD_CODE_W-1:0] pesd_code_t;  // event number field
  typedef logic [`PESD_AMT_W-1:0]  pesd_amt_t;   // per-cycle increment
endpackage : pesd_pkg

// file: pesd_event_decode.sv
// Functional notes
// [RL1] each counter decodes its own event field
// [RL2] duration adds per clock, occurrence per event
// [RL3] 1Fh counts address-generation interlock clocks
// [RL4] 23h-26h count breakpoint 0-3 matches
// [RL5] 28h counts reads and writes each
// [RL6] 29h counts read and write misses
// [RL7] 2Bh: X pipe on 0, Y on 1
// [RL8] 2Dh: state clear on 0, switches on 1
// [RL9] 31h multimedia data reads, counter 0 only
// [RL10] 37h: mispredicted returns 0, all predicted 1
// [RL11] 38h: multiply interlock 0, quadword stall 1
// [RL12] 3Ah: false entries 0, backward miss 1
// [RL13] 3Bh: write buffer stall 0, line stall 1
// [RL14] 40h counts second-level TLB misses
// [RL15] 41h-43h first-level data, code, either misses
// [RL16] 44h-46h flushes, invalidations, invalidation hits
// [RL17] reserved codes never advance a counter
`include "pesd_params.svh"
module pesd_event_decode
  import pesd_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  // event number fields of the two counters
  input  wire pesd_code_t event_sel0,
  input  wire pesd_code_t event_sel1,
  // bus and pipeline events, one-cycle pulses
  input  wire logic       locked_cycle,
  input  wire logic       io_cycle,
  input  wire logic       noncache_req,
  input  wire logic       fp_op,
  input  wire logic       hw_intr,
  input  wire logic       instr_decoded,
  // pipeline stall levels
  input  wire logic       agi_stall,
  input  wire logic       wb_full_stall,
  input  wire logic       mm_excl_write_stall,
  input  wire logic       mm_mul_interlock,
  input  wire logic       quadword_move_instr_stall,
  // debug breakpoint hits
  input  wire logic       debug_breakpoint_addr_0_hit,
  input  wire logic       debug_breakpoint_addr_1_hit,
  input  wire logic       debug_breakpoint_addr_2_hit,
  input  wire logic       debug_breakpoint_addr_3_hit,
  // data cache traffic
  input  wire logic       data_read,
  input  wire logic       data_write,
  input  wire logic       read_miss,
  input  wire logic       write_miss,
  // multimedia unit
  input  wire logic       mm_x_exec,
  input  wire logic       mm_y_exec,
  input  wire logic       multimedia_state_clear_instr_exec,
  input  wire logic       mm_fp_switch,
  input  wire logic       sat_instr,
  input  wire logic       sat_done,
  input  wire logic       mm_data_read,
  // branch prediction
  input  wire logic       taken_branch,
  input  wire logic       ret_exec,
  input  wire logic       ret_mispredict,
  input  wire logic       ret_predict,
  input  wire logic       return_stack_buffer_overflow,
  input  wire logic       branch_target_buffer_false,
  input  wire logic       branch_target_buffer_back_miss,
  // translation buffers
  input  wire logic       l2_tlb_code_miss,
  input  wire logic       l2_tlb_data_miss,
  input  wire logic       l1_tlb_data_miss,
  input  wire logic       l1_tlb_code_miss,
  input  wire logic       tlb_flush,
  input  wire logic       tlb_page_inval,
  input  wire logic       tlb_page_inval_hit,
  // increments for counter 0 and counter 1
  output pesd_amt_t       cnt0_inc,
  output pesd_amt_t       cnt1_inc
);

  // ==========================================================
  // helpers

  // widen one event bit to an increment
  function automatic pesd_amt_t pesd_one(input logic ev);
    pesd_one = {1'h0, ev};
  endfunction : pesd_one

  // two events that may land in the same clock
  function automatic pesd_amt_t pesd_two(input logic ev_a,
                                         input logic ev_b);
    pesd_two = pesd_one(ev_a) + pesd_one(ev_b);
  endfunction : pesd_two

  // ==========================================================
  // event decode, used once per counter
  // hi selects the counter 1 meaning of split codes
  function automatic pesd_amt_t pesd_decode(input pesd_code_t code,
                                            input logic       hi);
    pesd_amt_t a;
    a = `PESD_AMT_NONE;
    case (code)
      // common occurrence events
      `PESD_EV_LOCKED: a = pesd_one(locked_cycle);
      `PESD_EV_IOCYC:  a = pesd_one(io_cycle);
      `PESD_EV_NCREQ:  a = pesd_one(noncache_req);
      `PESD_EV_FPOP:   a = pesd_one(fp_op);
      `PESD_EV_HWINT:  a = pesd_one(hw_intr);
      `PESD_EV_DECODE: a = pesd_one(instr_decoded);
      // stall level counts every clock
      `PESD_EV_AGI:    a = pesd_one(agi_stall);          // [RL3] [RL2]
      // breakpoint matches
      `PESD_EV_BP0:    a = pesd_one(debug_breakpoint_addr_0_hit); // [RL4]
      `PESD_EV_BP1:    a = pesd_one(debug_breakpoint_addr_1_hit); // [RL4]
      `PESD_EV_BP2:    a = pesd_one(debug_breakpoint_addr_2_hit); // [RL4]
      `PESD_EV_BP3:    a = pesd_one(debug_breakpoint_addr_3_hit); // [RL4]
      // read and write in one clock count two
      `PESD_EV_RDWR:   a = pesd_two(data_read, data_write); // [RL5] [RL2]
      `PESD_EV_RWMISS: a = pesd_two(read_miss, write_miss); // [RL6]
      // split codes
      `PESD_EV_MMPIPE:
        a = pesd_one(hi ? mm_y_exec : mm_x_exec);        // [RL7]
      `PESD_EV_MMCLR:
        a = pesd_one(hi ? mm_fp_switch
                        : multimedia_state_clear_instr_exec); // [RL8]
      `PESD_EV_SAT:
        a = pesd_one(hi ? sat_done : sat_instr);
      // counter 0 only
      `PESD_EV_MMRD:
        a = pesd_one(!hi && mm_data_read);               // [RL9]
      // counter 1 only, then 37h split between the counters
      `PESD_EV_TAKEN:
        a = pesd_one(hi && taken_branch);
      `PESD_EV_RETPRED:
        a = pesd_one(hi ? ret_predict : ret_mispredict); // [RL10]
      // more split codes, 38h and 3Bh are durations
      `PESD_EV_MMSTALL:
        a = pesd_one(hi ? quadword_move_instr_stall
                        : mm_mul_interlock);             // [RL11] [RL2]
      `PESD_EV_RETURN:
        a = pesd_one(hi ? return_stack_buffer_overflow : ret_exec);
      `PESD_EV_BTBERR:
        a = pesd_one(hi ? branch_target_buffer_back_miss
                        : branch_target_buffer_false);   // [RL12]
      `PESD_EV_WRSTALL:
        a = pesd_one(hi ? mm_excl_write_stall
                        : wb_full_stall);                // [RL13] [RL2]
      // translation buffers
      `PESD_EV_L2TLB:
        a = pesd_two(l2_tlb_code_miss, l2_tlb_data_miss); // [RL14]
      `PESD_EV_L1TLBD: a = pesd_one(l1_tlb_data_miss);   // [RL15]
      `PESD_EV_L1TLBC: a = pesd_one(l1_tlb_code_miss);   // [RL15]
      `PESD_EV_L1TLB:
        a = pesd_two(l1_tlb_data_miss, l1_tlb_code_miss); // [RL15]
      `PESD_EV_FLUSH:  a = pesd_one(tlb_flush);          // [RL16]
      `PESD_EV_INVAL:  a = pesd_one(tlb_page_inval);     // [RL16]
      `PESD_EV_INVHIT: a = pesd_one(tlb_page_inval_hit); // [RL16]
      // reserved and unlisted codes stay silent
      default:         a = `PESD_AMT_NONE;               // [RL17]
    endcase
    pesd_decode = a;
  endfunction : pesd_decode

  // ==========================================================
  // increment state

  pesd_amt_t cnt0_inc_reg;   // registered increment, counter 0
  pesd_amt_t cnt0_inc_next;  // decoded increment, counter 0
  pesd_amt_t cnt1_inc_reg;   // registered increment, counter 1
  pesd_amt_t cnt1_inc_next;  // decoded increment, counter 1

  // each counter decodes only its own field
  always_comb begin
    cnt0_inc_next = pesd_decode(event_sel0, 1'h0); // [RL1]
    cnt1_inc_next = pesd_decode(event_sel1, 1'h1); // [RL1]
  end

  // register the increments, cleared by reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt0_inc_reg <= `PESD_AMT_NONE;
      cnt1_inc_reg <= `PESD_AMT_NONE;
    end else begin
      cnt0_inc_reg <= cnt0_inc_next;
      cnt1_inc_reg <= cnt1_inc_next;
    end
  end

  // outputs come straight from flops
  assign cnt0_inc = cnt0_inc_reg;
  assign cnt1_inc = cnt1_inc_reg;

  // ==========================================================
  // checks

  default clocking pesd_cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // counters with different fields decode apart
  a_sel_independent: assert property (  // [RL1]
    (event_sel0 == `PESD_EV_BP0 && event_sel1 == `PESD_EV_BP1 &&
     debug_breakpoint_addr_0_hit && !debug_breakpoint_addr_1_hit)
    |=> (cnt0_inc == `PESD_AMT_ONE && cnt1_inc == `PESD_AMT_NONE))
    else $error("counters did not decode their own fields");

  // a stall held three clocks gives three increments
  a_agi_duration: assert property (  // [RL3]
    (event_sel0 == `PESD_EV_AGI && agi_stall) [*3]
    |=> $past(cnt0_inc, 2) == `PESD_AMT_ONE &&
        $past(cnt0_inc) == `PESD_AMT_ONE && cnt0_inc == `PESD_AMT_ONE)
    else $error("interlock stall not counted each clock");

  // breakpoint 3 match on counter 1
  a_bp3_match: assert property (  // [RL4]
    (event_sel1 == `PESD_EV_BP3 && debug_breakpoint_addr_3_hit)
    |=> cnt1_inc == `PESD_AMT_ONE)
    else $error("breakpoint 3 match lost");

  // simultaneous read and write count two
  a_rdwr_pair: assert property (  // [RL5]
    (event_sel0 == `PESD_EV_RDWR && data_read && data_write)
    |=> cnt0_inc == `PESD_AMT_TWO)
    else $error("read plus write not counted as two");

  // a lone write miss counts one
  a_miss_single: assert property (  // [RL6]
    (event_sel1 == `PESD_EV_RWMISS && write_miss && !read_miss)
    |=> cnt1_inc == `PESD_AMT_ONE)
    else $error("write miss not counted");

  // Y pipe work does not reach counter 0
  a_pipe_split: assert property (  // [RL7]
    (event_sel0 == `PESD_EV_MMPIPE && event_sel1 == `PESD_EV_MMPIPE &&
     mm_y_exec && !mm_x_exec)
    |=> (cnt0_inc == `PESD_AMT_NONE && cnt1_inc == `PESD_AMT_ONE))
    else $error("pipe split wrong");

  // state clear never reaches counter 1
  a_clr_split: assert property (  // [RL8]
    (event_sel1 == `PESD_EV_MMCLR && multimedia_state_clear_instr_exec &&
     !mm_fp_switch) |=> cnt1_inc == `PESD_AMT_NONE)
    else $error("state clear leaked to counter 1");

  // multimedia data reads never on counter 1
  a_mmrd_c1: assert property (  // [RL9]
    (event_sel1 == `PESD_EV_MMRD) |=> cnt1_inc == `PESD_AMT_NONE)
    else $error("counter 1 advanced on counter 0 code");

  // a right prediction counts only on counter 1
  a_ret_split: assert property (  // [RL10]
    (event_sel0 == `PESD_EV_RETPRED && event_sel1 == `PESD_EV_RETPRED &&
     ret_predict && !ret_mispredict)
    |=> (cnt0_inc == `PESD_AMT_NONE && cnt1_inc == `PESD_AMT_ONE))
    else $error("return prediction split wrong");

  // both second-level misses in one clock count two
  a_l2_pair: assert property (  // [RL14]
    (event_sel0 == `PESD_EV_L2TLB && l2_tlb_code_miss && l2_tlb_data_miss)
    |=> cnt0_inc == `PESD_AMT_TWO)
    else $error("second-level misses not summed");

  // code-only selection ignores data misses
  a_l1_code: assert property (  // [RL15]
    (event_sel1 == `PESD_EV_L1TLBC && l1_tlb_data_miss && !l1_tlb_code_miss)
    |=> cnt1_inc == `PESD_AMT_NONE)
    else $error("data miss counted as code miss");

  // invalidation hit
  a_inval_hit: assert property (  // [RL16]
    (event_sel0 == `PESD_EV_INVHIT && tlb_page_inval_hit)
    |=> cnt0_inc == `PESD_AMT_ONE)
    else $error("invalidation hit lost");

  // reserved block stays silent
  a_rsvd_quiet: assert property (  // [RL17]
    (event_sel0 >= `PESD_EV_RSVD_LO && event_sel0 <= `PESD_EV_RSVD_HI)
    |=> cnt0_inc == `PESD_AMT_NONE)
    else $error("reserved code advanced counter 0");

  // multiply interlock counts on counter 0 only
  a_mul_split: assert property (  // [RL11]
    (event_sel0 == `PESD_EV_MMSTALL && event_sel1 == `PESD_EV_MMSTALL &&
     mm_mul_interlock && !quadword_move_instr_stall)
    |=> (cnt0_inc == `PESD_AMT_ONE && cnt1_inc == `PESD_AMT_NONE))
    else $error("multiply interlock split wrong");

  // backward-branch miss counts on counter 1 only
  a_btb_split: assert property (  // [RL12]
    (event_sel0 == `PESD_EV_BTBERR && event_sel1 == `PESD_EV_BTBERR &&
     branch_target_buffer_back_miss && !branch_target_buffer_false)
    |=> (cnt0_inc == `PESD_AMT_NONE && cnt1_inc == `PESD_AMT_ONE))
    else $error("target buffer split wrong");

  // full write buffers stall counter 0 only
  a_wbuf_split: assert property (  // [RL13]
    (event_sel0 == `PESD_EV_WRSTALL && event_sel1 == `PESD_EV_WRSTALL &&
     wb_full_stall && !mm_excl_write_stall)
    |=> (cnt0_inc == `PESD_AMT_ONE && cnt1_inc == `PESD_AMT_NONE))
    else $error("write buffer stall split wrong");

  // taken branches never reach counter 0
  a_taken_c0: assert property (  // [RL17]
    (event_sel0 == `PESD_EV_TAKEN) |=> cnt0_inc == `PESD_AMT_NONE)
    else $error("counter 0 advanced on reserved code");

  // lone reserved codes stay silent on counter 1
  a_rsvd_c1: assert property (  // [RL17]
    (event_sel1 == `PESD_EV_RSVD_47 || event_sel1 == `PESD_EV_RSVD_49)
    |=> cnt1_inc == `PESD_AMT_NONE)
    else $error("reserved code advanced counter 1");

endmodule : pesd_event_decode

// file: testbench.sv
// ============================================================
// self-checking bench for the event select decoder
module testbench
  import pesd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk;       // core clock
  logic        reset;      // synchronous reset, active high
  pesd_code_t  sel0;       // counter 0 event number
  pesd_code_t  sel1;       // counter 1 event number
  logic [39:0] ev;         // every event input, one bit each
  pesd_amt_t   cnt0_inc;   // counter 0 increment
  pesd_amt_t   cnt1_inc;   // counter 1 increment
  int          error_cnt;  // mismatches seen
  int          compares;   // comparisons made

  // ============================================================
  // design under test, each event input on its own bit
  pesd_event_decode DUT (
    .mclk(mclk), .reset(reset), .event_sel0(sel0), .event_sel1(sel1),
    .locked_cycle(ev[0]), .io_cycle(ev[1]), .noncache_req(ev[2]), .fp_op(ev[3]),
    .hw_intr(ev[4]), .instr_decoded(ev[5]), .agi_stall(ev[6]), .wb_full_stall(ev[7]),
    .mm_excl_write_stall(ev[8]), .mm_mul_interlock(ev[9]),
    .quadword_move_instr_stall(ev[10]), .debug_breakpoint_addr_0_hit(ev[11]),
    .debug_breakpoint_addr_1_hit(ev[12]), .debug_breakpoint_addr_2_hit(ev[13]),
    .debug_breakpoint_addr_3_hit(ev[14]), .data_read(ev[15]), .data_write(ev[16]),
    .read_miss(ev[17]), .write_miss(ev[18]), .mm_x_exec(ev[19]), .mm_y_exec(ev[20]),
    .multimedia_state_clear_instr_exec(ev[21]), .mm_fp_switch(ev[22]),
    .sat_instr(ev[23]), .sat_done(ev[24]), .mm_data_read(ev[25]),
    .taken_branch(ev[26]), .ret_exec(ev[27]), .ret_mispredict(ev[28]),
    .ret_predict(ev[29]), .return_stack_buffer_overflow(ev[30]),
    .branch_target_buffer_false(ev[31]), .branch_target_buffer_back_miss(ev[32]),
    .l2_tlb_code_miss(ev[33]), .l2_tlb_data_miss(ev[34]), .l1_tlb_data_miss(ev[35]),
    .l1_tlb_code_miss(ev[36]), .tlb_flush(ev[37]), .tlb_page_inval(ev[38]),
    .tlb_page_inval_hit(ev[39]), .cnt0_inc(cnt0_inc), .cnt1_inc(cnt1_inc));

  // ============================================================
  // clock, 4 ns period
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end

  // ============================================================
  // compare one value, count and report
  task automatic check(input pesd_amt_t seen, input pesd_amt_t exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t increment seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // drive selects and events, held until the next call, judge both increments a cycle later
  task automatic run_chk(input pesd_code_t s0, input pesd_code_t s1,
                         input logic [39:0] e, input pesd_amt_t x0, input pesd_amt_t x1);
    @(posedge mclk);
    sel0 <= s0;
    sel1 <= s1;
    ev   <= e;
    @(posedge mclk);
    #1;
    check(cnt0_inc, x0);
    check(cnt1_inc, x1);
  endtask : run_chk

  // ============================================================
  // codes meaning the same event on both counters
  task automatic t_shared();
    pesd_code_t sc [24] = '{6'h1c, 6'h1d, 6'h1e, 6'h22, 6'h27, 6'h48, 6'h1f, 6'h23,
                            6'h24, 6'h25, 6'h26, 6'h28, 6'h28, 6'h29, 6'h29, 6'h40,
                            6'h40, 6'h41, 6'h42, 6'h43, 6'h43, 6'h44, 6'h45, 6'h46};
    int         sb [24] = '{0, 1, 2, 3, 4, 5, 6, 11, 12, 13, 14, 15, 16, 17, 18,
                            33, 34, 35, 36, 35, 36, 37, 38, 39};
    for (int i = 0; i < 24; i++) begin
      run_chk(sc[i], sc[i], 40'h1 << sb[i], 2'h1, 2'h1);
      run_chk(sc[i], sc[i], 40'h0, 2'h0, 2'h0);
    end
    // a held stall adds one every clock
    repeat (3) run_chk(6'h1f, 6'h1f, 40'h1 << 6, 2'h1, 2'h1);
    run_chk(6'h28, 6'h28, 40'h3 << 15, 2'h2, 2'h2);
    run_chk(6'h29, 6'h29, 40'h3 << 17, 2'h2, 2'h2);
    run_chk(6'h40, 6'h40, 40'h3 << 33, 2'h2, 2'h2);
    run_chk(6'h43, 6'h43, 40'h3 << 35, 2'h2, 2'h2);
    // data-only and code-only misses ignore the other kind
    run_chk(6'h41, 6'h42, 40'h1 << 36, 2'h0, 2'h1);
    run_chk(6'h41, 6'h42, 40'h1 << 35, 2'h1, 2'h0);
    $display("test shared done");
  endtask : t_shared

  // ============================================================
  // codes whose event differs between the counters
  task automatic t_split();
    pesd_code_t pc [8] = '{6'h2b, 6'h2d, 6'h37, 6'h38, 6'h3a, 6'h3b, 6'h2f, 6'h39};
    int         b0 [8] = '{19, 21, 28, 9, 31, 7, 23, 27};
    int         b1 [8] = '{20, 22, 29, 10, 32, 8, 24, 30};
    for (int i = 0; i < 8; i++) begin
      run_chk(pc[i], pc[i], 40'h1 << b0[i], 2'h1, 2'h0);
      run_chk(pc[i], pc[i], 40'h1 << b1[i], 2'h0, 2'h1);
    end
    // multimedia reads only on counter 0
    run_chk(6'h31, 6'h31, 40'h1 << 25, 2'h1, 2'h0);
    // taken branches only on counter 1
    run_chk(6'h32, 6'h32, 40'h1 << 26, 2'h0, 2'h1);
    $display("test split done");
  endtask : t_split

  // ============================================================
  // each counter follows its own select, back to back
  task automatic t_indep();
    run_chk(6'h28, 6'h29, 40'h1 << 15, 2'h1, 2'h0);
    run_chk(6'h29, 6'h28, 40'h1 << 17, 2'h1, 2'h0);
    run_chk(6'h23, 6'h24, 40'h1 << 11, 2'h1, 2'h0);
    $display("test indep done");
  endtask : t_indep

  // ============================================================
  // reserved codes stay silent with every event raised
  task automatic t_reserved();
    pesd_code_t rc [16] = '{6'h20, 6'h21, 6'h2a, 6'h2c, 6'h33, 6'h34, 6'h35, 6'h36,
                            6'h3c, 6'h3d, 6'h3e, 6'h3f, 6'h47, 6'h49, 6'h2e, 6'h30};
    for (int i = 0; i < 16; i++) begin
      run_chk(rc[i], rc[i], {40{1'h1}}, 2'h0, 2'h0);
    end
    // codes that belong to the other counter only
    run_chk(6'h32, 6'h31, {40{1'h1}}, 2'h0, 2'h0);
    $display("test reserved done");
  endtask : t_reserved

  // ============================================================
  // reset in mid-run clears both increments, counting resumes after release
  task automatic t_reset();
    run_chk(6'h28, 6'h1f, (40'h1 << 15) | (40'h1 << 6), 2'h1, 2'h1);
    @(posedge mclk);
    reset <= 1'h1;
    @(posedge mclk);
    #1;
    check(cnt0_inc, 2'h0);
    check(cnt1_inc, 2'h0);
    @(posedge mclk);
    reset <= 1'h0;
    #1;
    check(cnt0_inc, 2'h0);
    check(cnt1_inc, 2'h0);
    @(posedge mclk);
    #1;
    check(cnt0_inc, 2'h1);
    check(cnt1_inc, 2'h1);
    $display("test reset done");
  endtask : t_reset

  // ============================================================
  // verdict and end of run
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // ============================================================
  // main sequence
  initial begin
    error_cnt = 0;
    compares  = 0;
    reset     = 1'h1;
    sel0      = 6'h00;
    sel1      = 6'h00;
    ev        = 40'h0;
    repeat (4) @(posedge mclk);
    reset <= 1'h0;
    t_shared();
    t_split();
    t_indep();
    t_reserved();
    t_reset();
    test_done();
  end

  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #20000;
    error_cnt++;
    test_done();
  end
endmodule : testbench
